// ==== core/omp_pkg.sv ====
// Purpose: shared constants and types for the or/copy/pointer-load executor
// Assumes: 16-bit instruction words, 8-bit data path, 12-bit data addresses
// Notes: opcode fields are matched on the upper bits of the instruction word
package omp_pkg;

    // instruction fields
    localparam logic [7:0] OPC_OR_LITERAL = 8'h09;        // bits 15:8
    localparam logic [5:0] OPC_OR_ACC_REG = 6'h04;        // bits 15:10, 0001 00
    localparam logic [5:0] OPC_COPY_REG = 6'h14;          // bits 15:10, 0101 00
    localparam logic [9:0] OPC_LOAD_POINTER = 10'h3b8;    // bits 15:6, 1110 1110 00
    localparam int BIT_DEST = 9;
    localparam int BIT_ACCESS = 8;
    localparam int PTR_SEL_LSB = 4;

    // access bank: low half maps to bank 0, upper half to the top bank
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
    localparam logic [1:0] PTR_COUNT = 2'h3;              // selectors 0..2 legal

    // reset values
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [3:0] BANK_RESET = 4'h0;
    localparam logic [11:0] PTR_RESET = 12'h000;

    // register port offsets
    localparam logic [3:0] REG_ACC = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_BANK = 4'h2;
    localparam logic [3:0] REG_PTR0_LOW = 4'h4;           // low byte at 4+2i, high at 5+2i

    // status register bit positions
    localparam int STAT_ZERO = 0;
    localparam int STAT_NEG = 1;
    localparam int STAT_WAIT2 = 2;
    localparam int STAT_BUSY = 3;

    // sequencer: fetch, then the four quarters of an instruction cycle
    typedef enum logic [2:0] {
        ST_FETCH,
        ST_Q1,
        ST_Q2,
        ST_Q3,
        ST_Q4
    } omp_state_type;

endpackage

// ==== core/omp_core.sv ====
// Purpose: decode and execute or-literal, or-acc-reg, copy-reg and pointer-load
// Assumes: instruction source and data memory run on mclk; memory reads return next cycle
// Notes: each instruction cycle is four mclk cycles, one per quarter
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module omp_core
    import omp_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // instruction stream
    input wire logic [15:0] instr_word,
    input wire logic instr_valid,
    output logic instr_ready,
    output logic instr_done,
    // data memory
    output logic [11:0] mem_addr,
    output logic mem_rd,
    input wire logic [7:0] mem_rdata,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // architectural state
    output logic [7:0] acc,
    output logic flag_n,
    output logic flag_z,
    output logic [3:0] bank_select_reg,
    output logic [11:0] pointer_reg0,
    output logic [11:0] pointer_reg1,
    output logic [11:0] pointer_reg2
);

    omp_state_type state;
    omp_state_type next_state;
    logic [15:0] op;
    logic phase2;
    logic wait_second;
    logic [1:0] ptr_sel;
    logic [7:0] result;
    logic [11:0] ptr_reg [3];

    // zero test used by the flag update; its check compares with 8'h00 directly
    function automatic logic is_zero(input logic [7:0] v);
        is_zero = (v == 8'h00);
    endfunction

    // register port read mux
    function automatic logic [7:0] read_mux(input logic [3:0] a, input logic [7:0] acc_v,
                                            input logic [7:0] stat_v, input logic [3:0] bank_v,
                                            input logic [11:0] p0, input logic [11:0] p1,
                                            input logic [11:0] p2);
        case (a)
            REG_ACC: read_mux = acc_v;
            REG_STATUS: read_mux = stat_v;
            REG_BANK: read_mux = {4'h0, bank_v};
            REG_PTR0_LOW: read_mux = p0[7:0];
            REG_PTR0_LOW + 4'h1: read_mux = {4'h0, p0[11:8]};
            REG_PTR0_LOW + 4'h2: read_mux = p1[7:0];
            REG_PTR0_LOW + 4'h3: read_mux = {4'h0, p1[11:8]};
            REG_PTR0_LOW + 4'h4: read_mux = p2[7:0];
            REG_PTR0_LOW + 4'h5: read_mux = {4'h0, p2[11:8]};
            default: read_mux = 8'h00;
        endcase
    endfunction

    // decode; a second pointer-load word is never decoded as an opcode
    wire is_or_lit = !phase2 && (op[15:8] == OPC_OR_LITERAL);
    wire is_or_reg = !phase2 && (op[15:10] == OPC_OR_ACC_REG);
    wire is_copy = !phase2 && (op[15:10] == OPC_COPY_REG);
    wire is_ptr_first = !phase2 && (op[15:6] == OPC_LOAD_POINTER);
    wire is_reg_op = is_or_reg || is_copy;
    wire sets_flags = is_or_lit || is_reg_op;
    wire dest_reg = op[BIT_DEST];
    wire accept = instr_ready && instr_valid;

    // effective address: access bank splits on the address msb
    wire [3:0] access_bank = (op[7:0] < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK;
    wire [3:0] eff_bank = op[BIT_ACCESS] ? bank_select_reg : access_bank;
    wire [11:0] eff_addr = {eff_bank, op[7:0]};

    // operand selection for the process quarter
    wire [7:0] or_operand = is_or_lit ? op[7:0] : mem_rdata;
    wire [7:0] next_result = is_copy ? mem_rdata : (acc | or_operand);
    wire write_acc = sets_flags && !(is_reg_op && dest_reg);
    wire [7:0] status_v = {4'h0, state != ST_FETCH, wait_second, flag_n, flag_z};
    wire bus_acc_wr = reg_wr && (reg_addr == REG_ACC);
    wire bus_bank_wr = reg_wr && (reg_addr == REG_BANK);

    // quarter sequencing: one mclk per quarter
    always_comb begin
        case (state)
            ST_FETCH: next_state = accept ? ST_Q1 : ST_FETCH;
            ST_Q1: next_state = ST_Q2;
            ST_Q2: next_state = ST_Q3;
            ST_Q3: next_state = ST_Q4;
            ST_Q4: next_state = ST_FETCH;
            default: next_state = ST_FETCH;
        endcase
    end

    // sequencer and instruction capture
    always_ff @(posedge mclk) begin
        if (srst) begin
            state <= ST_FETCH;
            instr_ready <= 1'b0;
            op <= 16'h0000;
            phase2 <= 1'b0;
        end else begin
            state <= next_state;
            instr_ready <= (next_state == ST_FETCH) && !(state == ST_FETCH && accept);
            if (accept) begin
                op <= instr_word;
                phase2 <= wait_second;
            end
        end
    end

    // data memory: read in Q2, write-back in Q4
    always_ff @(posedge mclk) begin
        if (srst) begin
            mem_addr <= 12'h000;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_wdata <= 8'h00;
        end else begin
            mem_rd <= (state == ST_Q1) && is_reg_op;
            if (state == ST_Q1) begin
                mem_addr <= eff_addr;
            end
            mem_wr <= (state == ST_Q3) && is_reg_op && dest_reg;
            if (state == ST_Q3) begin
                mem_wdata <= next_result;
            end
        end
    end

    // process quarter result
    always_ff @(posedge mclk) begin
        if (srst) begin
            result <= 8'h00;
        end else if (state == ST_Q3) begin
            result <= next_result;
        end
    end

    // accumulator and flags, written in Q4; instruction beats a bus write
    always_ff @(posedge mclk) begin
        if (srst) begin
            acc <= ACC_RESET;
            flag_n <= 1'b0;
            flag_z <= 1'b0;
        end else if (state == ST_Q4 && sets_flags) begin
            if (write_acc) begin
                acc <= result;
            end
            flag_n <= result[7];
            flag_z <= is_zero(result);
        end else if (bus_acc_wr) begin
            acc <= reg_wdata;
        end
    end

    // pointer load: high part on first word, low byte on second
    always_ff @(posedge mclk) begin
        if (srst) begin
            ptr_reg[0] <= PTR_RESET;
            ptr_reg[1] <= PTR_RESET;
            ptr_reg[2] <= PTR_RESET;
            ptr_sel <= 2'h0;
            wait_second <= 1'b0;
        end else begin
            if (accept) begin
                wait_second <= 1'b0;
            end
            if (state == ST_Q4 && is_ptr_first) begin
                ptr_sel <= op[PTR_SEL_LSB +: 2];
                wait_second <= 1'b1;
                if (op[PTR_SEL_LSB +: 2] < PTR_COUNT) begin
                    ptr_reg[op[PTR_SEL_LSB +: 2]][11:8] <= op[3:0];
                end
            end
            if (state == ST_Q4 && phase2 && ptr_sel < PTR_COUNT) begin
                ptr_reg[ptr_sel][7:0] <= op[7:0];
            end
        end
    end

    // bank select and register port answers; read data only the cycle after
    always_ff @(posedge mclk) begin
        if (srst) begin
            bank_select_reg <= BANK_RESET;
            reg_rdata <= 8'h00;
            instr_done <= 1'b0;
        end else begin
            if (bus_bank_wr) begin
                bank_select_reg <= reg_wdata[3:0];
            end
            reg_rdata <= reg_rd ? read_mux(reg_addr, acc, status_v, bank_select_reg,
                                           ptr_reg[0], ptr_reg[1], ptr_reg[2]) : 8'h00;
            instr_done <= (state == ST_Q4);
        end
    end

    assign pointer_reg0 = ptr_reg[0];
    assign pointer_reg1 = ptr_reg[1];
    assign pointer_reg2 = ptr_reg[2];

    // helper: quarters since the word was taken; a stuck sequencer shows up as a run-away count
    logic [2:0] busy_cnt;
    always_ff @(posedge mclk) begin
        if (srst) begin
            busy_cnt <= 3'h0;
        end else begin
            busy_cnt <= (state == ST_FETCH) ? 3'h0 : busy_cnt + 3'h1;
        end
    end

    // checks
    a_or_literal_acc: assert property (@(posedge mclk) disable iff (srst)
        (state == ST_Q3 && is_or_lit) |=> ##1 acc == ($past(acc, 2) | $past(op[7:0], 2)))
        else $error("or-literal result not in accumulator");
    a_quarter_span: assert property (@(posedge mclk) disable iff (srst)
        (state == ST_Q1) |=> (state == ST_Q2) ##1 (state == ST_Q3) ##1 (state == ST_Q4)
        ##1 (state == ST_FETCH && instr_done))
        else $error("instruction cycle not four quarters");
    a_or_reg_value: assert property (@(posedge mclk) disable iff (srst)
        (state == ST_Q3 && is_or_reg) |=> result == ($past(acc) | $past(mem_rdata)))
        else $error("or-acc-reg result wrong");
    a_access_bank: assert property (@(posedge mclk) disable iff (srst)
        (state == ST_Q2 && is_reg_op && !op[BIT_ACCESS]) |->
        mem_addr[11:8] == (op[7] ? ACCESS_HIGH_BANK : ACCESS_LOW_BANK))
        else $error("access bank not used");
    a_pointer_low: assert property (@(posedge mclk) disable iff (srst)
        (state == ST_Q4 && phase2 && ptr_sel == 2'h1) |=> ptr_reg[1][7:0] == $past(op[7:0]))
        else $error("pointer low byte not loaded");
    a_pointer_no_flag: assert property (@(posedge mclk) disable iff (srst)
        (state == ST_Q4 && (is_ptr_first || phase2)) |=> $stable(flag_n) && $stable(flag_z))
        else $error("pointer load touched flags");
    a_copy_value: assert property (@(posedge mclk) disable iff (srst)
        (state == ST_Q3 && is_copy) |=> result == $past(mem_rdata))
        else $error("copy-reg value wrong");
    a_dest_writeback: assert property (@(posedge mclk) disable iff (srst)
        (state == ST_Q3 && is_reg_op && dest_reg) |=> mem_wr && mem_wdata == result
        && mem_addr == $past(mem_addr) ##1 !mem_wr)
        else $error("write-back to register missing");
    a_flag_values: assert property (@(posedge mclk) disable iff (srst)
        (state == ST_Q4 && sets_flags) |=> flag_n == $past(result[7])
        && flag_z == ($past(result) == 8'h00))
        else $error("flags do not follow result");
    a_read_quarter: assert property (@(posedge mclk) disable iff (srst)
        (state == ST_Q1 && is_reg_op) |=> mem_rd ##1 !mem_rd)
        else $error("register read not in second quarter");

    // quarter timing and destination routing
    a_ready_busy: assert property (@(posedge mclk) disable iff (srst)
        (state != ST_FETCH) |-> !instr_ready)
        else $error("ready raised inside an instruction cycle");
    a_done_pulse: assert property (@(posedge mclk) disable iff (srst)
        instr_done |=> !instr_done)
        else $error("done pulse longer than one cycle");
    a_cycle_bound: assert property (@(posedge mclk) disable iff (srst)
        busy_cnt <= 3'h4)
        else $error("instruction cycle longer than four quarters");
    a_literal_no_mem: assert property (@(posedge mclk) disable iff (srst)
        (state == ST_Q1 && is_or_lit) |=> (!mem_rd && !mem_wr) ##1 (!mem_rd && !mem_wr) ##1 !mem_wr)
        else $error("or-literal touched data memory");
    a_dest_acc_write: assert property (@(posedge mclk) disable iff (srst)
        (state == ST_Q4 && is_reg_op && !dest_reg) |=> acc == $past(result))
        else $error("register op result not in accumulator");
    a_dest_keeps_acc: assert property (@(posedge mclk) disable iff (srst)
        (state == ST_Q4 && is_reg_op && dest_reg) |=> $stable(acc))
        else $error("write-back op changed accumulator");
    a_dest_no_write: assert property (@(posedge mclk) disable iff (srst)
        (state == ST_Q3 && is_reg_op && !dest_reg) |=> !mem_wr)
        else $error("accumulator destination wrote memory");

    // selector 2 loads its high nibble; selector 3 is outside the three pointers and must leave them all alone
    a_pointer_high: assert property (@(posedge mclk) disable iff (srst)
        (state == ST_Q4 && is_ptr_first && op[PTR_SEL_LSB +: 2] == 2'h2) |=>
        ptr_reg[2][11:8] == $past(op[3:0]))
        else $error("pointer high nibble not loaded");
    a_pointer_sel_idle: assert property (@(posedge mclk) disable iff (srst)
        (state == ST_Q4 && is_ptr_first && op[PTR_SEL_LSB +: 2] == 2'h3) |=>
        $stable(pointer_reg0) && $stable(pointer_reg1) && $stable(pointer_reg2))
        else $error("illegal pointer selector wrote a pointer");

endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// Purpose: self-checking bench for the or/copy/pointer-load executor
// Assumes: the bench answers memory reads itself, data valid in the Q3 cycle only
// Notes: random ops from a fixed seed plus corner cases; a small model tracks acc, flags, bank, pointers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import omp_pkg::*;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [15:0] instr_word = 16'h0000;
    logic instr_valid = 1'b0;
    logic [7:0] mem_rdata = 8'h00;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    wire logic instr_ready, instr_done, mem_rd, mem_wr, flag_n, flag_z;
    wire logic [11:0] mem_addr, pointer_reg0, pointer_reg1, pointer_reg2;
    wire logic [7:0] mem_wdata, reg_rdata, acc;
    wire logic [3:0] bank_select_reg;
    // reference state, updated from the instruction semantics and from the bench's own register writes
    logic [7:0] m_acc = 8'h00;
    logic m_n = 1'b0;
    logic m_z = 1'b0;
    logic [3:0] m_bank = 4'h0;
    logic [11:0] m_ptr [3];
    int error_cnt = 0;
    int total_checks = 0;
    int cycles = 0;

    omp_core dut (.mclk(mclk), .srst(srst), .instr_word(instr_word), .instr_valid(instr_valid),
        .instr_ready(instr_ready), .instr_done(instr_done), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_rdata(mem_rdata), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc(acc),
        .flag_n(flag_n), .flag_z(flag_z), .bank_select_reg(bank_select_reg),
        .pointer_reg0(pointer_reg0), .pointer_reg1(pointer_reg1), .pointer_reg2(pointer_reg2));

    // 40 MHz clock
    always #12.5 mclk = ~mclk;

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // expected data address; access bank splits at the fixed offset
    function automatic logic [11:0] exp_addr(input logic a, input logic [7:0] f);
        if (a) return {m_bank, f};
        return {(f < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK, f};
    endfunction

    task automatic check_state();
        check(acc, m_acc, "accumulator");
        check(flag_n, m_n, "negative flag");
        check(flag_z, m_z, "zero flag");
        check(bank_select_reg, m_bank, "bank");
        check(pointer_reg0, m_ptr[0], "pointer 0");
        check(pointer_reg1, m_ptr[1], "pointer 1");
        check(pointer_reg2, m_ptr[2], "pointer 2");
    endtask

    // one word through all four quarters; live low marks a pointer-load second word
    task automatic exec(input logic [15:0] w, input logic [7:0] data, input logic live);
        logic lit, regop, dst;
        logic [7:0] res;
        int k;
        lit = live && (w[15:8] == OPC_OR_LITERAL);
        regop = live && (w[15:10] == OPC_OR_ACC_REG || w[15:10] == OPC_COPY_REG);
        dst = regop && w[BIT_DEST];
        res = (w[15:10] == OPC_COPY_REG) ? data : lit ? (m_acc | w[7:0]) : (m_acc | data);
        instr_valid <= 1'b1;
        instr_word <= w;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (instr_ready !== 1'b1 && k < 20);
        instr_valid <= 1'b0;
        instr_word <= 16'($urandom);
        if (lit || (regop && !dst)) m_acc = res;
        if (lit || regop) begin
            m_n = res[7];
            m_z = (res == 8'h00);
        end
        for (k = 1; k <= 5; k++) begin
            @(posedge mclk);
            if (k == 2) mem_rdata <= data;
            if (k == 3) mem_rdata <= ~data;
            check(mem_rd, regop && k == 2, "read strobe");
            check(mem_wr, dst && k == 4, "write strobe");
            check(instr_done, k == 5, "done pulse");
            check(instr_ready, k == 5, "ready while busy");
            if (k == 2 && regop) check(mem_addr, exp_addr(w[BIT_ACCESS], w[7:0]), "address");
            if (k == 4 && dst) check(mem_wdata, res, "write data");
        end
        check_state();
    endtask

    // extra edge after the strobe so two writes never share a time step
    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
        d = reg_rdata;
    endtask

    task automatic ptr_load(input logic [1:0] sel, input logic [11:0] kv);
        logic [7:0] v;
        if (sel != 2'h3) m_ptr[sel][11:8] = kv[11:8];
        exec({OPC_LOAD_POINTER, sel, kv[11:8]}, 8'h00, 1'b1);
        reg_read(REG_STATUS, v);
        check(v[STAT_WAIT2], 1'b1, "second word wait");
        if (sel != 2'h3) m_ptr[sel][7:0] = kv[7:0];
        exec({8'($urandom), kv[7:0]}, 8'($urandom), 1'b0);
    endtask

    initial begin
        logic [7:0] v;
        logic [7:0] off;
        int i;
        for (i = 0; i < 3; i++) m_ptr[i] = PTR_RESET;
        void'($urandom(73));
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        repeat (2) @(posedge mclk);
        check_state();
        // or-literal worked example, then access-bank split edges and zero result
        reg_write(REG_ACC, 8'h9a);
        m_acc = 8'h9a;
        exec({OPC_OR_LITERAL, 8'h35}, 8'h00, 1'b1);
        check(acc, 8'hbf, "or literal value");
        reg_write(REG_BANK, 8'h05);
        m_bank = 4'h5;
        exec({OPC_COPY_REG, 2'b01, 8'h10}, 8'h00, 1'b1);
        exec({OPC_OR_ACC_REG, 2'b10, 8'h7f}, 8'h80, 1'b1);
        exec({OPC_OR_ACC_REG, 2'b10, 8'h80}, 8'h01, 1'b1);
        reg_read(REG_STATUS, v);
        check(v[1:0], {m_n, m_z}, "status flags");
        reg_read(4'hf, v);
        check(v, 8'h00, "unmapped read");
        reg_write(REG_PTR0_LOW, 8'h55);
        for (i = 0; i < 4; i++) ptr_load(2'(i), 12'($urandom));
        // random mix of all four operations
        for (i = 0; i < 48; i++) begin
            off = 8'($urandom);
            if (i % 8 == 0) begin
                m_bank = 4'($urandom);
                reg_write(REG_BANK, {4'h0, m_bank});
            end
            case ($urandom % 4)
                0: exec({OPC_OR_LITERAL, off}, 8'($urandom), 1'b1);
                1: exec({OPC_OR_ACC_REG, 2'($urandom), off}, 8'($urandom), 1'b1);
                2: exec({OPC_COPY_REG, 2'($urandom), off}, 8'($urandom), 1'b1);
                default: ptr_load(2'($urandom % 3), 12'($urandom));
            endcase
        end
        reg_read(REG_ACC, v);
        check(v, m_acc, "acc readback");
        print_verdict();
    end
endmodule
`default_nettype wire
